// >>> hdl/apfm_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef APFM_REGS_VH
`define APFM_REGS_VH
`define APFM_CLK_HZ          10000000
`define APFM_RETRY_MS        50
`define APFM_RETRY_CYC       ((`APFM_CLK_HZ / 1000) * `APFM_RETRY_MS)
`define APFM_CNT_W           20
`define APFM_ADDR_W          5
`define APFM_OFS_STATUS      5'h00
`define APFM_OFS_LIVE        5'h04
`define APFM_OFS_CTRL        5'h08
`define APFM_OFS_STATE       5'h0c
`define APFM_CTRL_RST        4'h0
`define APFM_CTRL_FAULT_PIN_N_SUP   0
`define APFM_CTRL_SHUT_DIS   1
`define APFM_CTRL_CLIP_CLIP  2
`define APFM_CTRL_CLIP_WARN  3
`define APFM_ST_SHORT1       0
`define APFM_ST_SHORT2       1
`define APFM_ST_OFFSET       2
`define APFM_ST_OTP          3
`define APFM_ST_UV           4
`define APFM_ST_OV           5
`define APFM_ST_WIN1         6
`define APFM_ST_WIN2         7
`define APFM_ST_POR          8
`define APFM_ST_W            9
`define APFM_RESP_OKAY       2'b00
`define APFM_RESP_SLVERR     2'b10
`endif

// >>> hdl/apfm_fault_manager.v
// protection fault manager for a dual-channel class-d amplifier
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "apfm_regs.vh"
// Function
// - foldback reduces gain, never shuts down
// - overtemperature: full shutdown, restart on clear
// - current limit keeps outputs switching
// - short: affected channel off, retry 50 ms
// - supply short: window check blocks restart
// - startup waits until outputs read open
// - offset watched in mute and operate
// - bus mode: offset alarm, optional fault_pin_n
// - bus mode: offset shutdown unless disabled
// - offset shutdown latched until enable toggle
// - strap mode: offset always fault_pin_n, shutdown
// - offset strap disabled ignores offsets
// - undervoltage: mute, stop, auto restart
// - overvoltage: full shutdown, restart on clear
// - bus-mode deep drop needs host command
// - fault_pin_n and clip pins are open-drain
// - short drives fault_pin_n low, latches status
// - latched status clears on bus read
// - fault_pin_n pin follows live faults
// - fault to pin routing
module apfm_fault_manager
(
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        bus_mode,
   input  wire        enable,
   input  wire        offset_strap_en,
   input  wire        deep_drop,
   input  wire        restart_cmd,
   input  wire        thermal_foldback,
   input  wire        overtemp,
   input  wire        overcurrent_guard,
   input  wire [1:0]  short_load,
   input  wire [1:0]  short_supply,
   input  wire [1:0]  window_short,
   input  wire        offset_guard,
   input  wire        undervoltage_guard,
   input  wire        overvoltage_guard,
   input  wire        clip_detect,
   input  wire        temp_warn,
   input  wire        in_standby,
   output reg         gain_reduce,
   output reg         current_limit,
   output reg         mute,
   output reg  [1:0]  chan_on,
   output reg         startup_hold,
   output wire        fault_pin_n_o,
   output wire        fault_pin_n_oe,
   output wire        clip_pin_n_o,
   output wire        clip_pin_n_oe,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   localparam NSYNC = 13;
   // 20 bits cover the 50 ms retry count at 10 MHz
   localparam integer RETRY_INT = `APFM_RETRY_CYC;
   localparam [`APFM_CNT_W-1:0] RETRY_CYC = RETRY_INT[`APFM_CNT_W-1:0];
   localparam [1:0] ST_RUN  = 2'h0;
   localparam [1:0] ST_OFF  = 2'h1;
   localparam [1:0] ST_WAIT = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for comparator inputs
   // bit order fixes the s_* slices below
   wire [NSYNC-1:0] raw_in;
   assign raw_in = {thermal_foldback,
                    overtemp,
                    overcurrent_guard,
                    short_load,
                    short_supply,
                    offset_guard,
                    undervoltage_guard,
                    overvoltage_guard,
                    clip_detect,
                    temp_warn,
                    window_short[0]};
   reg  [NSYNC-1:0] meta_q;
   reg  [NSYNC-1:0] sync_q;
   reg              win1_meta_q;
   reg              win1_q;
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         meta_q      <= {NSYNC{1'b0}};
         sync_q      <= {NSYNC{1'b0}};
         win1_meta_q <= 1'b0;
         win1_q      <= 1'b0;
      end
      else
      begin
         meta_q      <= raw_in;
         sync_q      <= meta_q;
         win1_meta_q <= window_short[1];
         win1_q      <= win1_meta_q;
      end
   end
   wire       s_tfp = sync_q[12];
   wire       s_otp = sync_q[11];
   wire       s_ocp = sync_q[10];
   wire [1:0] s_sl  = sync_q[9:8];
   wire [1:0] s_ss  = sync_q[7:6];
   wire       s_dc  = sync_q[5];
   wire       s_uv  = sync_q[4];
   wire       s_ov  = sync_q[3];
   wire       s_clp = sync_q[2];
   wire       s_tw  = sync_q[1];
   wire [1:0] s_win = {win1_q, sync_q[0]};

   ////////////////////////////////////////////////////////////////////////
   // control register and offset latch
   reg  [3:0] ctrl_q;
   reg        enable_q;
   reg        offset_lat_q;
   reg        por_hold_q;
   wire       dc_active = offset_strap_en & s_dc;
   wire       dc_shut   = dc_active & (~bus_mode |
                          ~ctrl_q[`APFM_CTRL_SHUT_DIS]);
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         enable_q     <= 1'b0;
         offset_lat_q <= 1'b0;
         por_hold_q   <= 1'b1;
      end
      else
      begin
         enable_q <= enable;
         // a change on enable re-arms a latched offset shutdown once dc_shut is low
         if (dc_shut)
            offset_lat_q <= 1'b1;
         else if ((enable != enable_q) | ~offset_strap_en)
            offset_lat_q <= 1'b0;
         // deep drop in bus mode holds until a host command
         if (bus_mode & deep_drop)
            por_hold_q <= 1'b1;
         else if (restart_cmd | ~bus_mode)
            por_hold_q <= 1'b0;
      end
   end

   // undervoltage is left out of hard_off so it can mute first
   wire hard_off = s_otp | s_ov | offset_lat_q | por_hold_q
                   | ~enable_q;
   wire full_off = hard_off | s_uv;

   ////////////////////////////////////////////////////////////////////////
   // per-channel short handling and retry timer
   wire [1:0] ch_run;
   wire [3:0] ch_state;
   wire [1:0] ch_hit;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : ch
         reg [1:0]             cst_q;
         reg [`APFM_CNT_W-1:0] cnt_q;
         reg                   hit_q;
         always @(posedge ref_clk)
         begin
            if (rst)
            begin
               cst_q <= ST_RUN;
               cnt_q <= {`APFM_CNT_W{1'b0}};
               hit_q <= 1'b0;
            end
            else
            begin
               case (cst_q)
                  ST_RUN:
                  begin
                     if (s_sl[g] | s_ss[g])
                     begin
                        cst_q <= ST_OFF;
                        cnt_q <= {`APFM_CNT_W{1'b0}};
                        hit_q <= s_ss[g];
                     end
                  end
                  ST_OFF:
                  begin
                     // a short still present trips again on the next cycle
                     if (cnt_q == RETRY_CYC - 1'b1)
                     begin
                        cnt_q <= {`APFM_CNT_W{1'b0}};
                        if (hit_q & s_win[g])
                           cst_q <= ST_WAIT;
                        else
                        begin
                           cst_q <= ST_RUN;
                           hit_q <= 1'b0;
                        end
                     end
                     else
                        cnt_q <= cnt_q + 1'b1;
                  end
                  ST_WAIT:
                  begin
                     if (~s_win[g])
                     begin
                        cst_q <= ST_RUN;
                        hit_q <= 1'b0;
                     end
                  end
                  default:
                     cst_q <= ST_RUN;
               endcase
            end
         end
         assign ch_run[g]           = (cst_q == ST_RUN);
         assign ch_state[2*g+1:2*g] = cst_q;
         assign ch_hit[g]           = hit_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // amplifier control outputs
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         gain_reduce   <= 1'b0;
         current_limit <= 1'b0;
         mute          <= 1'b1;
         chan_on       <= 2'b00;
         startup_hold  <= 1'b0;
      end
      else
      begin
         gain_reduce   <= s_tfp;
         current_limit <= s_ocp & ~(|s_sl) & ~(|s_ss);
         mute          <= full_off;
         // undervoltage mutes first, power stage stops next cycle
         chan_on[0] <= ~hard_off & ~mute & ch_run[0]
                       & ~(in_standby & |s_win);
         chan_on[1] <= ~hard_off & ~mute & ch_run[1]
                       & ~(in_standby & |s_win);
         startup_hold <= in_standby & |s_win;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin routing, open drain: oe low drives low
   // pins follow live inputs, never the status latches
   wire dc_fault_pin_n = dc_active & (~bus_mode |
                  ~ctrl_q[`APFM_CTRL_FAULT_PIN_N_SUP]);
   wire fault_pin_n_on = por_hold_q | s_uv | s_ov | s_otp | (|s_sl) | (|s_ss)
                  | s_ocp | (|s_win) | dc_fault_pin_n;
   // strap mode has no control bits, so both sources show
   wire clip_sel = s_clp & (~bus_mode | ctrl_q[`APFM_CTRL_CLIP_CLIP]);
   wire warn_sel = s_tw & (~bus_mode | ctrl_q[`APFM_CTRL_CLIP_WARN]);
   wire clip_on  = por_hold_q | clip_sel | warn_sel;
   assign fault_pin_n_o  = 1'b0;
   assign fault_pin_n_oe = ~fault_pin_n_on;
   assign clip_pin_n_o   = 1'b0;
   assign clip_pin_n_oe  = ~clip_on;

   ////////////////////////////////////////////////////////////////////////
   // latched status, set wins over read clear
   reg  [`APFM_ST_W-1:0] stat_q;
   wire [`APFM_ST_W-1:0] live;
   assign live = {por_hold_q,
                  s_win[1] & ch_hit[1],
                  s_win[0] & ch_hit[0],
                  s_ov,
                  s_uv,
                  s_otp,
                  dc_active,
                  s_sl[1] | s_ss[1],
                  s_sl[0] | s_ss[0]};
   wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
   // clear only on the exact status word, never on a refused address
   wire rd_clr = rd_go & (s_axi_araddr == `APFM_OFS_STATUS);
   always @(posedge ref_clk)
   begin
      if (rst)
         stat_q <= {`APFM_ST_W{1'b0}};
      else if (rd_clr)
         stat_q <= live;
      else
         stat_q <= stat_q | live;
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave, one cycle answer
   // aw and w are taken together; a pending response refuses both
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_q       <= `APFM_CTRL_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `APFM_RESP_OKAY;
      end
      else
      begin
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr == `APFM_OFS_CTRL)
            begin
               s_axi_bresp <= `APFM_RESP_OKAY;
               if (s_axi_wstrb[0])
                  ctrl_q <= s_axi_wdata[3:0];
            end
            else
               s_axi_bresp <= `APFM_RESP_SLVERR;
         end
      end
   end
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `APFM_RESP_OKAY;
      end
      else
      begin
         if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `APFM_RESP_OKAY;
            case (s_axi_araddr)
               `APFM_OFS_STATUS: s_axi_rdata <= {23'h0, stat_q};
               `APFM_OFS_LIVE:   s_axi_rdata <= {23'h0, live};
               `APFM_OFS_CTRL:   s_axi_rdata <= {28'h0, ctrl_q};
               `APFM_OFS_STATE:  s_axi_rdata <= {22'h0,
                                                 startup_hold,
                                                 chan_on,
                                                 mute,
                                                 current_limit,
                                                 gain_reduce,
                                                 ch_state};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `APFM_RESP_SLVERR;
               end
            endcase
         end
      end
   end

endmodule

// >>> tb/apfm_chk.sv
// concurrent checks on the fault manager outputs
`timescale 1ns/10ps
module apfm_chk
(
   input wire       ref_clk,
   input wire       rst,
   input wire       bus_mode,
   input wire       offset_strap_en,
   input wire       thermal_foldback,
   input wire       overtemp,
   input wire       overcurrent_guard,
   input wire [1:0] short_load,
   input wire [1:0] short_supply,
   input wire       offset_guard,
   input wire       undervoltage_guard,
   input wire       overvoltage_guard,
   input wire       gain_reduce,
   input wire       current_limit,
   input wire       mute,
   input wire [1:0] chan_on,
   input wire       fault_pin_n_o,
   input wire       fault_pin_n_oe,
   input wire       clip_pin_n_o
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // four samples cover two sync stages and the output register
   a_fold_gain: assert property (thermal_foldback [*4] |-> gain_reduce)
      else $error("foldback without gain cut");
   a_ot_off: assert property (overtemp [*4] |-> chan_on == 2'h0)
      else $error("overtemp left a channel on");
   a_oc_limit: assert property
      ((overcurrent_guard && short_load == 2'h0 && short_supply == 2'h0) [*4]
       |-> current_limit)
      else $error("no current limiting");
   a_short_pin: assert property
      ((overcurrent_guard || short_load != 2'h0) [*3] |-> !fault_pin_n_oe)
      else $error("fault pin released on short");
   a_strap_ofs: assert property
      ((offset_guard && offset_strap_en && !bus_mode) [*5] |-> chan_on == 2'h0)
      else $error("strap offset kept channels on");
   a_uv_mute: assert property (undervoltage_guard [*4] |-> mute)
      else $error("undervoltage without mute");
   a_ov_off: assert property
      (overvoltage_guard [*4] |-> chan_on == 2'h0)
      else $error("overvoltage left a channel on");
   a_open_drain: assert property (!fault_pin_n_o && !clip_pin_n_o)
      else $error("open-drain pin driven high");
endmodule
bind apfm_fault_manager apfm_chk u_chk (.*);

// >>> tb/apfm_host.sv
// host model: axi4-lite master issuing single register cycles
`timescale 1ns/10ps
module apfm_host
(
   input  wire         ref_clk,
   output logic [4:0]  s_axi_awaddr,
   output logic        s_axi_awvalid,
   input  wire         s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0]  s_axi_wstrb,
   output logic        s_axi_wvalid,
   input  wire         s_axi_wready,
   input  wire  [1:0]  s_axi_bresp,
   input  wire         s_axi_bvalid,
   output logic        s_axi_bready,
   output logic [4:0]  s_axi_araddr,
   output logic        s_axi_arvalid,
   input  wire         s_axi_arready,
   input  wire  [31:0] s_axi_rdata,
   input  wire  [1:0]  s_axi_rresp,
   input  wire         s_axi_rvalid,
   output logic        s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 39'h0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 8'h0;
      s_axi_wstrb = 4'hf;
   end
   // handshakes are sampled at the rise that completes them
   task xfer(input logic w, input logic [4:0] a, input logic [31:0] v,
             output logic [31:0] d, output logic [1:0] r);
      logic tk, dn;
      begin
         @(posedge ref_clk);
         {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
         {s_axi_arvalid, s_axi_rready} <= {2{!w}};
         dn = 1'b0;
         while (!dn)
         begin
            @(posedge ref_clk);
            tk = s_axi_awready | s_axi_arready;
            dn = w ? s_axi_bvalid : s_axi_rvalid;
            d = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            if (tk)
               {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
            if (dn)
               {s_axi_bready, s_axi_rready} <= 2'h0;
         end
      end
   endtask
endmodule

// >>> tb/apfm_fault_manager_tb_top.sv
// self-checking bench for the amplifier fault manager
`timescale 1ns/10ps
`include "apfm_regs.vh"
module apfm_fault_manager_tb_top;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        bus_mode, enable, offset_strap_en, deep_drop, restart_cmd;
   logic        thermal_foldback, overtemp, overcurrent_guard, offset_guard;
   logic        undervoltage_guard, overvoltage_guard, clip_detect, temp_warn;
   logic        in_standby, gain_reduce, current_limit, mute, startup_hold;
   logic        fault_pin_n_o, fault_pin_n_oe, clip_pin_n_o, clip_pin_n_oe;
   logic [1:0]  short_load, short_supply, window_short, chan_on, r;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [15:0] rows [0:12];
   int          fail_count = 0;
   int          checks_done = 0;
   // pull-ups on the open-drain pins
   wire         fault_pin_n = fault_pin_n_oe ? 1'b1 : fault_pin_n_o;
   wire         clip_pin_n = clip_pin_n_oe ? 1'b1 : clip_pin_n_o;
   wire  [5:0]  o = {gain_reduce, current_limit, chan_on, fault_pin_n,
                     clip_pin_n};
   apfm_fault_manager uut (.*);
   apfm_host host (.*);
   always #50 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////////////////////
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      begin
         checks_done++;
         if (s !== e)
         begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d failures %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial
   begin
      tick(3000);
      fail_count++;
      print_verdict;
   end
////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {bus_mode, deep_drop, restart_cmd, in_standby, offset_guard} = 5'h0;
      {thermal_foldback, overtemp, overcurrent_guard, clip_detect} = 4'h0;
      {undervoltage_guard, overvoltage_guard, temp_warn} = 3'h0;
      {short_load, short_supply, window_short} = 6'h0;
      {enable, offset_strap_en} = 2'h3;
      // faults, {offset, strap, enable}, expected outputs
      rows = '{{7'h00, 3'h3, 6'h0f}, {7'h40, 3'h3, 6'h2f},
               {7'h10, 3'h3, 6'h1d}, {7'h02, 3'h3, 6'h0e},
               {7'h01, 3'h3, 6'h0e}, {7'h20, 3'h3, 6'h01},
               {7'h00, 3'h3, 6'h0f}, {7'h08, 3'h3, 6'h01},
               {7'h00, 3'h3, 6'h0f}, {7'h04, 3'h3, 6'h01},
               {7'h00, 3'h3, 6'h0f}, {7'h00, 3'h5, 6'h0f},
               {7'h00, 3'h7, 6'h01}};
      tick(4);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         {thermal_foldback, overtemp, overcurrent_guard, undervoltage_guard,
          overvoltage_guard, clip_detect, temp_warn, offset_guard,
          offset_strap_en, enable} <= rows[i][15:6];
         tick(6);
         chk("row", o, rows[i][5:0]);
      end
      offset_guard <= 1'b0;
      tick(6);
      chk("latch", chan_on, 2'h0);
      enable <= 1'b0;
      tick(3);
      enable <= 1'b1;
      tick(6);
      chk("rearm", chan_on, 2'h3);
      host.xfer(1'b0, `APFM_OFS_STATUS, 32'h0, d, r);
      chk("history", d & 32'h38, 32'h38);
      host.xfer(1'b0, `APFM_OFS_STATUS, 32'h0, d, r);
      chk("live", d, 32'h0);
      bus_mode <= 1'b1;
      host.xfer(1'b1, `APFM_OFS_CTRL, 32'h3, d, r);
      chk("ctrl resp", r, `APFM_RESP_OKAY);
      host.xfer(1'b0, `APFM_OFS_CTRL, 32'h0, d, r);
      chk("ctrl", d, 32'h3);
      offset_guard <= 1'b1;
      tick(6);
      chk("bus offset", o, 6'h0f);
      host.xfer(1'b0, `APFM_OFS_STATUS, 32'h0, d, r);
      chk("alarm", d[2], 1'b1);
      offset_guard <= 1'b0;
      host.xfer(1'b1, `APFM_OFS_STATUS, 32'h0, d, r);
      chk("ro resp", r, `APFM_RESP_SLVERR);
      host.xfer(1'b0, 5'h10, 32'h0, d, r);
      chk("hole resp", r, `APFM_RESP_SLVERR);
      chk("hole data", d, 32'h0);
      deep_drop <= 1'b1;
      tick(6);
      deep_drop <= 1'b0;
      tick(6);
      chk("por hold", o, 6'h00);
      restart_cmd <= 1'b1;
      tick(1);
      restart_cmd <= 1'b0;
      tick(6);
      chk("restart", o, 6'h0f);
      in_standby <= 1'b1;
      window_short <= 2'h2;
      tick(6);
      chk("start hold", {startup_hold, chan_on, fault_pin_n}, 4'h8);
      in_standby <= 1'b0;
      window_short <= 2'h0;
      tick(6);
      chk("start go", {startup_hold, chan_on, fault_pin_n}, 4'h7);
      short_load <= 2'h1;
      tick(6);
      chk("short", o, 6'h09);
      short_load <= 2'h0;
      tick(6);
      chk("retry wait", o, 6'h0b);
      host.xfer(1'b0, `APFM_OFS_STATUS, 32'h0, d, r);
      chk("short bit", d[0], 1'b1);
      rst <= 1'b1;
      tick(2);
      chk("reset", {mute, chan_on}, 3'h4);
      rst <= 1'b0;
      tick(6);
      chk("por", o, 6'h00);
      host.xfer(1'b0, `APFM_OFS_CTRL, 32'h0, d, r);
      chk("ctrl reset", d, `APFM_CTRL_RST);
      print_verdict;
   end
endmodule
